// File: src/ipc_input_loop_ctrl.sv
// Input loop divider and charge pump control registers.
// Assumes the serial control port logic drives the byte access port, the
// update strobe and the two outside control bits on this same clock.
//
// Overview of operation
// - The first reference divide ratio is a 10-bit word from 0x010 and 0x011[1:0], 0 and 1 mean one.
// - The second reference divide ratio is a 10-bit word from 0x012 and 0x013[1:0], 0 and 1 mean one.
// - The second reference divider uses its own word only while the independence bit is one.
// - The test reference divide ratio is 0x014[5:0], 0 and 1 mean one, bits 7:6 are reserved.
// - The feedback divide ratio is a 10-bit word from 0x016 and 0x017[1:0], 0 and 1 mean one.
// - Bit 7 of 0x018 puts the charge pump output into high impedance.
// - Bits 6:0 of 0x018 set the charge pump current magnitude.
// - Bit 4 of 0x019 at zero leaves the antibacklash period automatic, at one bits 3:2 set it.
// - The antibacklash field codes minimum, low, high and maximum, minimum by default.
// - Bits 1:0 of 0x019 select tristate, pump up, pump down or normal, normal by default.
// - Written values reach the logic only on the next update strobe, readback picks either copy.
module ipc_input_loop_ctrl
  import ipc_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire ipc_addr_t reg_addr,
  input wire logic wr_en,
  input wire ipc_byte_t wr_data,
  output ipc_byte_t rd_data,
  input wire logic io_update,
  input wire logic readback_buffered,
  input wire logic ref_b_independent,
  output ipc_ctrl_t ctrl
);

  ipc_regs_t buf_ff;
  ipc_regs_t nxt_buf;
  ipc_regs_t act_ff;
  ipc_regs_t nxt_act;
  ipc_regs_t rb_src;
  ipc_ctrl_t ctrl_ff;
  ipc_ctrl_t nxt_ctrl;
  ipc_byte_t rd_data_ff;
  ipc_byte_t nxt_rd;

  wire logic sel_a_lo = wr_en && (reg_addr == ADDR_REF_A_LO);
  wire logic sel_a_hi = wr_en && (reg_addr == ADDR_REF_A_HI);
  wire logic sel_b_lo = wr_en && (reg_addr == ADDR_REF_B_LO);
  wire logic sel_b_hi = wr_en && (reg_addr == ADDR_REF_B_HI);
  wire logic sel_test = wr_en && (reg_addr == ADDR_TEST_DIV);
  wire logic sel_fb_lo = wr_en && (reg_addr == ADDR_FB_LO);
  wire logic sel_fb_hi = wr_en && (reg_addr == ADDR_FB_HI);
  wire logic sel_cur = wr_en && (reg_addr == ADDR_PUMP_CUR);
  wire logic sel_mode = wr_en && (reg_addr == ADDR_PUMP_MODE);

  // Writes land in the buffer only; reserved bits are simply not stored.
  always_comb begin
    nxt_buf = buf_ff;
    if (sel_a_lo) begin
      nxt_buf.a_ratio[7:0] = wr_data;
    end
    if (sel_a_hi) begin
      nxt_buf.a_ratio[9:8] = wr_data[HI_MSB:0];
    end
    if (sel_b_lo) begin
      nxt_buf.b_ratio[7:0] = wr_data;
    end
    if (sel_b_hi) begin
      nxt_buf.b_ratio[9:8] = wr_data[HI_MSB:0];
    end
    if (sel_test) begin
      nxt_buf.test_ratio = wr_data[TEST_MSB:0];
    end
    if (sel_fb_lo) begin
      nxt_buf.fb_ratio[7:0] = wr_data;
    end
    if (sel_fb_hi) begin
      nxt_buf.fb_ratio[9:8] = wr_data[HI_MSB:0];
    end
    if (sel_cur) begin
      nxt_buf.cp_tri = wr_data[TRI_BIT];
      nxt_buf.cp_cur = wr_data[CUR_MSB:0];
    end
    if (sel_mode) begin
      nxt_buf.abl_manual = wr_data[ABL_MAN_BIT];
      nxt_buf.abl_width = ipc_abl_t'(wr_data[ABL_MSB:ABL_LSB]);
      nxt_buf.cp_mode = ipc_pump_mode_t'(wr_data[MODE_MSB:0]);
    end
  end

  // The whole buffer moves across in one edge, so a divider never sees half a
  // word; a write in the same cycle as the strobe is included.
  assign nxt_act = io_update ? nxt_buf : act_ff;

  // Effective settings: codes zero and one both give divide by one.
  wire logic [9:0] eff_a = (act_ff.a_ratio == RATIO10_ZERO) ? RATIO10_ONE : act_ff.a_ratio;
  wire logic [9:0] eff_b_own = (act_ff.b_ratio == RATIO10_ZERO) ? RATIO10_ONE : act_ff.b_ratio;
  wire logic [5:0] eff_test = (act_ff.test_ratio == RATIO6_ZERO) ? RATIO6_ONE :
                              act_ff.test_ratio;
  wire logic [9:0] eff_fb = (act_ff.fb_ratio == RATIO10_ZERO) ? RATIO10_ONE : act_ff.fb_ratio;

  always_comb begin
    nxt_ctrl.a_ratio = eff_a;
    nxt_ctrl.b_ratio = ref_b_independent ? eff_b_own : eff_a;
    nxt_ctrl.test_ratio = eff_test;
    nxt_ctrl.fb_ratio = eff_fb;
    nxt_ctrl.cp_hiz = act_ff.cp_tri || (act_ff.cp_mode == PUMP_TRI);
    nxt_ctrl.cp_cur = act_ff.cp_cur;
    nxt_ctrl.cp_mode = act_ff.cp_tri ? PUMP_TRI : act_ff.cp_mode;
    nxt_ctrl.abl_auto = !act_ff.abl_manual;
    nxt_ctrl.abl_width = act_ff.abl_width;
  end

  // Readback shows the buffer or the active copy, reserved bits as zero.
  assign rb_src = readback_buffered ? buf_ff : act_ff;

  always_comb begin
    nxt_rd = '0;
    case (reg_addr)
      ADDR_REF_A_LO: nxt_rd = rb_src.a_ratio[7:0];
      ADDR_REF_A_HI: nxt_rd[HI_MSB:0] = rb_src.a_ratio[9:8];
      ADDR_REF_B_LO: nxt_rd = rb_src.b_ratio[7:0];
      ADDR_REF_B_HI: nxt_rd[HI_MSB:0] = rb_src.b_ratio[9:8];
      ADDR_TEST_DIV: nxt_rd[TEST_MSB:0] = rb_src.test_ratio;
      ADDR_FB_LO: nxt_rd = rb_src.fb_ratio[7:0];
      ADDR_FB_HI: nxt_rd[HI_MSB:0] = rb_src.fb_ratio[9:8];
      ADDR_PUMP_CUR: nxt_rd = {rb_src.cp_tri, rb_src.cp_cur};
      ADDR_PUMP_MODE: begin
        nxt_rd[ABL_MAN_BIT] = rb_src.abl_manual;
        nxt_rd[ABL_MSB:ABL_LSB] = rb_src.abl_width;
        nxt_rd[MODE_MSB:0] = rb_src.cp_mode;
      end
      default: nxt_rd = '0;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      buf_ff <= REGS_RST;
      act_ff <= REGS_RST;
      rd_data_ff <= '0;
    end else begin
      buf_ff <= nxt_buf;
      act_ff <= nxt_act;
      rd_data_ff <= nxt_rd;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ctrl_ff.a_ratio <= RATIO10_ONE;
      ctrl_ff.b_ratio <= RATIO10_ONE;
      ctrl_ff.test_ratio <= RATIO6_ONE;
      ctrl_ff.fb_ratio <= RATIO10_ONE;
      ctrl_ff.cp_hiz <= 1'b0;
      ctrl_ff.cp_cur <= REGS_RST.cp_cur;
      ctrl_ff.cp_mode <= PUMP_NORMAL;
      ctrl_ff.abl_auto <= 1'b1;
      ctrl_ff.abl_width <= ABL_MIN;
    end else begin
      ctrl_ff <= nxt_ctrl;
    end
  end

  assign ctrl = ctrl_ff;
  assign rd_data = rd_data_ff;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  sequence s_write_no_update;
    wr_en && !io_update;
  endsequence

  sequence s_quiet_update;
    io_update && !wr_en;
  endsequence

  a_ratio_a_floor: assert property (ctrl.a_ratio != RATIO10_ZERO)
    else $error("first reference ratio reached zero");

  a_ratio_a_value: assert property (
    s_quiet_update ##1 !io_update |=> ctrl.a_ratio ==
      (($past(buf_ff.a_ratio, 2) == RATIO10_ZERO) ? RATIO10_ONE : $past(buf_ff.a_ratio, 2)))
    else $error("first reference ratio not applied from buffer");

  a_ratio_b_follow: assert property (
    $past(!ref_b_independent) |-> ctrl.b_ratio == ctrl.a_ratio)
    else $error("second reference ratio not tied to the first");

  a_ratio_test_range: assert property (
    ctrl.test_ratio != RATIO6_ZERO && ctrl.test_ratio <= RATIO6_MAX)
    else $error("test reference ratio out of range");

  a_ratio_fb_floor: assert property (ctrl.fb_ratio != RATIO10_ZERO)
    else $error("feedback ratio reached zero");

  a_pump_tri_override: assert property (
    $past(act_ff.cp_tri) |-> ctrl.cp_hiz && ctrl.cp_mode == PUMP_TRI)
    else $error("tristate bit did not override the pump");

  a_pump_cur_hold: assert property (
    s_write_no_update ##1 !io_update [*2] |-> $stable(ctrl.cp_cur))
    else $error("pump current changed without an update");

  a_abl_auto_mode: assert property (
    $past(act_ff.abl_manual) != ctrl.abl_auto)
    else $error("antibacklash auto flag wrong");

  a_active_hold: assert property (
    !io_update |=> $stable(act_ff))
    else $error("active copy changed without an update");

  a_readback_reserved: assert property (
    reg_addr == ADDR_RESERVED |=> rd_data == '0)
    else $error("reserved register read nonzero");

  // The checks below tie the outputs other than a_ratio and abl_auto to the active copy one edge
  // earlier, so a late or early transfer through ctrl_ff is caught as well.
  a_ratio_b_own: assert property (
    $past(ref_b_independent) |-> ctrl.b_ratio ==
      (($past(act_ff.b_ratio) == RATIO10_ZERO) ? RATIO10_ONE : $past(act_ff.b_ratio)))
    else $error("second reference ratio not taken from its own word");

  a_ratio_b_floor: assert property (ctrl.b_ratio != RATIO10_ZERO)
    else $error("second reference ratio reached zero");

  a_ratio_test_value: assert property (
    ctrl.test_ratio ==
      (($past(act_ff.test_ratio) == RATIO6_ZERO) ? RATIO6_ONE : $past(act_ff.test_ratio)))
    else $error("test reference ratio not applied from active copy");

  a_ratio_fb_value: assert property (
    ctrl.fb_ratio ==
      (($past(act_ff.fb_ratio) == RATIO10_ZERO) ? RATIO10_ONE : $past(act_ff.fb_ratio)))
    else $error("feedback ratio not applied from active copy");

  a_pump_cur_value: assert property (
    ctrl.cp_cur == $past(act_ff.cp_cur))
    else $error("pump current not applied from active copy");

  a_pump_mode_value: assert property (
    !$past(act_ff.cp_tri) |-> ctrl.cp_mode == $past(act_ff.cp_mode))
    else $error("pump mode not applied from active copy");

  a_pump_mode_hiz: assert property (
    $past(act_ff.cp_mode) == PUMP_TRI |-> ctrl.cp_hiz)
    else $error("tristate mode did not float the pump");

  a_abl_width_value: assert property (
    ctrl.abl_width == $past(act_ff.abl_width))
    else $error("antibacklash width not applied from active copy");

  a_buf_a_low: assert property (
    sel_a_lo |=> buf_ff.a_ratio[7:0] == $past(wr_data))
    else $error("first reference low byte not stored");

  a_buf_a_high: assert property (
    sel_a_hi |=> buf_ff.a_ratio[9:8] == $past(wr_data[HI_MSB:0]))
    else $error("first reference high bits not stored");

  a_buf_test_land: assert property (
    sel_test |=> buf_ff.test_ratio == $past(wr_data[TEST_MSB:0]))
    else $error("test reference ratio not stored");

  a_buf_fb_low: assert property (
    sel_fb_lo |=> buf_ff.fb_ratio[7:0] == $past(wr_data))
    else $error("feedback low byte not stored");

  a_update_copy: assert property (
    s_quiet_update |=> act_ff == $past(buf_ff))
    else $error("update did not copy the whole buffer");

  a_readback_buf: assert property (
    readback_buffered && reg_addr == ADDR_FB_LO |=> rd_data == $past(buf_ff.fb_ratio[7:0]))
    else $error("buffered readback wrong");

  a_readback_act: assert property (
    !readback_buffered && reg_addr == ADDR_REF_A_LO |=>
      rd_data == $past(act_ff.a_ratio[7:0]))
    else $error("active readback wrong");

  a_readback_unmapped: assert property (
    (reg_addr < ADDR_REF_A_LO || reg_addr > ADDR_PUMP_MODE) |=> rd_data == '0)
    else $error("unmapped register read nonzero");

endmodule : ipc_input_loop_ctrl

// File: src/ipc_pkg.sv
// Package for the input loop divider and charge pump control block.
// Assumes one 20 MHz clock shared with the serial control port logic.
package ipc_pkg;

  localparam int ADDR_W = 12;
  localparam int DATA_W = 8;

  typedef logic [ADDR_W-1:0] ipc_addr_t;
  typedef logic [DATA_W-1:0] ipc_byte_t;

  localparam ipc_addr_t ADDR_REF_A_LO = 12'h010;
  localparam ipc_addr_t ADDR_REF_A_HI = 12'h011;
  localparam ipc_addr_t ADDR_REF_B_LO = 12'h012;
  localparam ipc_addr_t ADDR_REF_B_HI = 12'h013;
  localparam ipc_addr_t ADDR_TEST_DIV = 12'h014;
  localparam ipc_addr_t ADDR_RESERVED = 12'h015;
  localparam ipc_addr_t ADDR_FB_LO = 12'h016;
  localparam ipc_addr_t ADDR_FB_HI = 12'h017;
  localparam ipc_addr_t ADDR_PUMP_CUR = 12'h018;
  localparam ipc_addr_t ADDR_PUMP_MODE = 12'h019;

  // Field positions inside the register bytes.
  localparam int HI_MSB = 1;
  localparam int TEST_MSB = 5;
  localparam int CUR_MSB = 6;
  localparam int TRI_BIT = 7;
  localparam int ABL_MAN_BIT = 4;
  localparam int ABL_MSB = 3;
  localparam int ABL_LSB = 2;
  localparam int MODE_MSB = 1;

  typedef enum logic [1:0] {
    PUMP_TRI = 2'h0,
    PUMP_UP = 2'h1,
    PUMP_DOWN = 2'h2,
    PUMP_NORMAL = 2'h3
  } ipc_pump_mode_t;

  typedef enum logic [1:0] {
    ABL_MIN = 2'h0,
    ABL_LOW = 2'h1,
    ABL_HIGH = 2'h2,
    ABL_MAX = 2'h3
  } ipc_abl_t;

  // Raw programmed fields, held once as a buffer and once as the active copy.
  typedef struct packed {
    logic [9:0] a_ratio;
    logic [9:0] b_ratio;
    logic [5:0] test_ratio;
    logic [9:0] fb_ratio;
    logic cp_tri;
    logic [6:0] cp_cur;
    logic abl_manual;
    ipc_abl_t abl_width;
    ipc_pump_mode_t cp_mode;
  } ipc_regs_t;

  // Effective settings handed to the dividers and the charge pump.
  typedef struct packed {
    logic [9:0] a_ratio;
    logic [9:0] b_ratio;
    logic [5:0] test_ratio;
    logic [9:0] fb_ratio;
    logic cp_hiz;
    logic [6:0] cp_cur;
    ipc_pump_mode_t cp_mode;
    logic abl_auto;
    ipc_abl_t abl_width;
  } ipc_ctrl_t;

  localparam logic [9:0] RATIO10_ONE = 10'h001;
  localparam logic [5:0] RATIO6_ONE = 6'h01;
  localparam logic [9:0] RATIO10_ZERO = 10'h000;
  localparam logic [5:0] RATIO6_ZERO = 6'h00;
  localparam logic [5:0] RATIO6_MAX = 6'h3F;

  localparam ipc_regs_t REGS_RST = '{
    a_ratio: 10'h001,
    b_ratio: 10'h000,
    test_ratio: 6'h01,
    fb_ratio: 10'h001,
    cp_tri: 1'b0,
    cp_cur: 7'h00,
    abl_manual: 1'b0,
    abl_width: ABL_MIN,
    cp_mode: PUMP_NORMAL
  };

endpackage : ipc_pkg

// File: testbench/ipc_input_loop_ctrl_tb.sv
// Self-checking bench for the input loop divider and charge pump control block.
// Assumes the package and the design module are compiled first.
module ipc_input_loop_ctrl_tb
  import ipc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk, rst_n, wr_en, io_update, readback_buffered, ref_b_independent;
  ipc_addr_t reg_addr;
  ipc_byte_t wr_data, rd_data;
  ipc_ctrl_t ctrl;
  int error_cnt, checked;
  logic [7:0] bm [10];
  logic [7:0] am [10];
  localparam logic [7:0] MASK [10] = '{8'hFF, 8'h03, 8'hFF, 8'h03, 8'h3F, 8'h00, 8'hFF, 8'h03,
    8'hFF, 8'h1F};
  localparam logic [7:0] RSTV [10] = '{8'h01, 8'h00, 8'h00, 8'h00, 8'h01, 8'h00, 8'h01, 8'h00,
    8'h00, 8'h03};
  localparam logic [9:0] CORNER [4] = '{10'h000, 10'h001, 10'h3FF, 10'h2AA};

  ipc_input_loop_ctrl dut (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .wr_en(wr_en),
    .wr_data(wr_data), .rd_data(rd_data), .io_update(io_update),
    .readback_buffered(readback_buffered), .ref_b_independent(ref_b_independent), .ctrl(ctrl));

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  function automatic logic [9:0] fix10(logic [9:0] r);
    return (r == 10'h000) ? 10'h001 : r;
  endfunction : fix10

  function automatic ipc_ctrl_t exp_ctrl();
    ipc_ctrl_t e;
    e.a_ratio = fix10({am[1][1:0], am[0]});
    e.b_ratio = ref_b_independent ? fix10({am[3][1:0], am[2]}) : e.a_ratio;
    e.test_ratio = (am[4][5:0] == 6'h00) ? 6'h01 : am[4][5:0];
    e.fb_ratio = fix10({am[7][1:0], am[6]});
    e.cp_hiz = am[8][7] | (am[9][1:0] == 2'h0);
    e.cp_cur = am[8][6:0];
    e.cp_mode = am[8][7] ? PUMP_TRI : ipc_pump_mode_t'(am[9][1:0]);
    e.abl_auto = ~am[9][4];
    e.abl_width = ipc_abl_t'(am[9][3:2]);
    return e;
  endfunction : exp_ctrl

  task automatic fail(string m);
    error_cnt++;
    $display("ERROR t=%0t %s", $time, m);
  endtask : fail

  task automatic chk_byte(ipc_byte_t got, ipc_byte_t e, ipc_addr_t a);
    checked++;
    if (got !== e) fail($sformatf("read %h got %h exp %h", a, got, e));
  endtask : chk_byte

  task automatic chk_ctrl();
    ipc_ctrl_t e, g;
    e = exp_ctrl();
    g = ctrl;
    // The width field only matters while the period is under manual control.
    if (e.abl_auto) begin
      e.abl_width = ABL_MIN;
      g.abl_width = ABL_MIN;
    end
    checked++;
    if (g !== e) fail($sformatf("ctrl got %h exp %h", g, e));
  endtask : chk_ctrl

  task automatic wr(ipc_addr_t a, ipc_byte_t d, logic u);
    reg_addr = a;
    wr_data = d;
    wr_en = 1'b1;
    io_update = u;
    if (a >= ADDR_REF_A_LO && a <= ADDR_PUMP_MODE) bm[int'(a) - 16] = d & MASK[int'(a) - 16];
    if (u) am = bm;
    @(negedge clk);
    wr_en = 1'b0;
    io_update = 1'b0;
  endtask : wr

  task automatic upd();
    io_update = 1'b1;
    am = bm;
    @(negedge clk);
    io_update = 1'b0;
    @(negedge clk);
  endtask : upd

  task automatic rd(ipc_addr_t a, logic b);
    ipc_byte_t e;
    reg_addr = a;
    readback_buffered = b;
    @(negedge clk);
    e = 8'h00;
    if (a >= ADDR_REF_A_LO && a <= ADDR_PUMP_MODE) e = b ? bm[int'(a) - 16] : am[int'(a) - 16];
    chk_byte(rd_data, e, a);
  endtask : rd

  task automatic rd_all();
    for (int i = 0; i < 13; i++) begin
      rd((i < 10) ? 12'(16 + i) : ((i == 10) ? 12'h01A : 12'hFFF), 1'b1);
      rd((i < 10) ? 12'(16 + i) : 12'h000, 1'b0);
    end
  endtask : rd_all

  task automatic end_sim();
    $display("checked %0d error_cnt %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : end_sim

  initial begin
    repeat (20000) @(posedge clk);
    fail("watchdog expired");
    end_sim();
  end

  initial begin
    logic u;
    {rst_n, wr_en, io_update, readback_buffered, ref_b_independent} = 5'h00;
    reg_addr = 12'h000;
    wr_data = 8'h00;
    error_cnt = 0;
    checked = 0;
    bm = RSTV;
    am = RSTV;
    void'($urandom(32'h8f44));
    repeat (20) @(negedge clk);
    rst_n = 1'b1;
    chk_ctrl();
    rd_all();
    $display("test reset done");
    for (int i = 0; i < 10; i++) wr(12'(16 + i), 8'($urandom), 1'b0);
    chk_ctrl();
    rd_all();
    ref_b_independent = 1'b1;
    upd();
    chk_ctrl();
    rd_all();
    $display("test staged writes done");
    for (int k = 0; k < 8; k++) begin
      wr(ADDR_REF_A_LO, CORNER[k % 4][7:0], 1'b0);
      wr(ADDR_REF_A_HI, {6'h3F, CORNER[k % 4][9:8]}, 1'b0);
      wr(ADDR_REF_B_LO, CORNER[(k + 1) % 4][7:0], 1'b0);
      wr(ADDR_REF_B_HI, {6'h3F, CORNER[(k + 1) % 4][9:8]}, 1'b0);
      wr(ADDR_TEST_DIV, {2'h3, CORNER[k % 4][5:0]}, 1'b0);
      wr(ADDR_FB_HI, {6'h3F, CORNER[(k + 2) % 4][9:8]}, 1'b0);
      ref_b_independent = k[2];
      wr(ADDR_FB_LO, CORNER[(k + 2) % 4][7:0], 1'b1);
      @(negedge clk);
      chk_ctrl();
    end
    $display("test ratio corners done");
    for (int k = 0; k < 64; k++) begin
      wr(ADDR_PUMP_CUR, {k[0], 7'($urandom)}, 1'b0);
      wr(ADDR_PUMP_MODE, {3'h7, k[1], k[3:2], k[5:4]}, 1'b0);
      upd();
      chk_ctrl();
    end
    rd_all();
    $display("test pump modes done");
    repeat (300) begin
      u = ($urandom % 4) == 0;
      ref_b_independent = 1'($urandom);
      wr(12'(16 + $urandom % 11), 8'($urandom), u);
      if (u) begin
        @(negedge clk);
        chk_ctrl();
      end
      rd(12'(16 + $urandom % 11), 1'($urandom));
    end
    $display("test random traffic done");
    rst_n = 1'b0;
    repeat (2) @(negedge clk);
    rst_n = 1'b1;
    bm = RSTV;
    am = RSTV;
    chk_ctrl();
    rd_all();
    $display("test second reset done");
    end_sim();
  end
endmodule : ipc_input_loop_ctrl_tb
